// [hdl/hsr_consts.vh]
// Purpose: constants shared by the host strobe and indirect readback block
// Assumes: sixteen-bit host data bus, three direct address lines
// Notes:   offsets are the device's internal write and read locations
`ifndef HSR_CONSTS_VH
`define HSR_CONSTS_VH

// ****************************************************************
// direct addresses on the host bus
// ****************************************************************
`define HSR_DA_DATA_LO 3'h0
`define HSR_DA_DATA_HI 3'h1
`define HSR_DA_WR_ADDR 3'h2
`define HSR_DA_RD_ADDR 3'h3

// ****************************************************************
// global write locations and the ild read location
// ****************************************************************
`define HSR_GWA_TEST_ENI 16'hF808
`define HSR_GWA_SYNC_OUT 16'hF809
`define HSR_GWA_SLOT_BASE 11'h7C1
`define HSR_GRA_ILD 16'hF806

// ****************************************************************
// per-channel offsets, channel nibble in bits 15:12
// ****************************************************************
`define HSR_CH_GLOBAL 4'hF
`define HSR_OFS_CARRIER 12'h006
`define HSR_OFS_TIMING 12'h009
`define HSR_OFS_WAIT 12'h00C
`define HSR_OFS_AGC 12'h00F
`define HSR_OFS_MEM_LO 12'h100
`define HSR_OFS_MEM_HI 12'h5FF

// ****************************************************************
// channel control bits and slot fields
// ****************************************************************
`define HSR_CTRL_ENI_LEVEL 11
`define HSR_CTRL_ENI_SRC 12
`define HSR_SLOT_W 5
`define HSR_SLOT_N 32
`define HSR_DT_I_HI 3'h0
`define HSR_DT_I_LO 3'h1
`define HSR_DT_Q_HI 3'h2
`define HSR_DT_Q_LO 3'h3
`define HSR_DT_MAG_HI 3'h4
`define HSR_DT_MAG_LO 3'h5
`define HSR_DT_PHASE 3'h6
`define HSR_DT_GAIN 3'h7

`endif

// [hdl/hsr_pin_sync.v]
// Purpose: two-stage synchroniser for host bus pins
// Assumes: pins change asynchronously to core_clk
// Notes:   the first stage is read only by the second stage
`timescale 1ns/1ns
`default_nettype none

module hsr_pin_sync #(
  parameter W = 1
) (
  input wire core_clk,
  input wire reset,
  input wire [W-1:0] pin_in,
  input wire [W-1:0] rst_val,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // ****************************************************************
  // two flops, reset to the idle pin level
  // ****************************************************************
  always @(posedge core_clk) begin
    if (reset) begin
      meta_q <= rst_val;
      sync_q <= rst_val;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule
`default_nettype wire

// [hdl/hsr_host_strobe.v]
// Purpose: host strobes, fifo read-order slots and indirect readback
// Assumes: host pins asynchronous; channel data and memories on core_clk
// Notes:   a write acts on the rising edge of the synchronised write pin
`timescale 1ns/1ns
`default_nettype none
`include "hsr_consts.vh"

module hsr_host_strobe (
  input wire core_clk,
  input wire reset,
  input wire ce_n,
  input wire wr_n,
  input wire rd_n,
  input wire [2:0] addr,
  input wire [15:0] p_in,
  output wire [15:0] p_out,
  output wire p_oe,
  input wire [3:0] ch_eni_level,
  input wire [3:0] ch_eni_src,
  output wire [3:0] input_enable_strobe,
  output wire sync_out_pin,
  input wire sync_in_pin,
  output wire sync_event,
  input wire [4:0] fifo_slot_idx,
  input wire [95:0] i_data,
  input wire [95:0] q_data,
  input wire [95:0] mag_data,
  input wire [63:0] phase_data,
  input wire [63:0] agc_gain,
  output wire [1:0] fifo_chan,
  output wire [15:0] fifo_word,
  input wire [127:0] carrier_freq,
  input wire [127:0] timing_freq,
  input wire [127:0] wait_counts,
  input wire [31:0] ild_result,
  output wire mem_fetch,
  output wire [15:0] mem_addr,
  input wire [31:0] mem_rd_data
);

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  wire [21:0] pins_s;
  wire sync_in_s;

  hsr_pin_sync #(.W(22)) u_bus_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pin_in({ce_n, wr_n, rd_n, addr, p_in}),
    .rst_val({3'h7, 3'h0, 16'h0000}),
    .sync_out(pins_s)
  );

  hsr_pin_sync #(.W(1)) u_syncin_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pin_in(sync_in_pin),
    .rst_val(1'b0),
    .sync_out(sync_in_s)
  );

  wire ce_s = pins_s[21];
  wire wr_s = pins_s[20];
  wire rd_s = pins_s[19];
  wire [2:0] addr_s = pins_s[18:16];
  wire [15:0] data_s = pins_s[15:0];

  // ****************************************************************
  // write completion: rising edge of the synchronised write pin
  // ****************************************************************
  reg wr_prev_q;
  reg ce_prev_q;
  wire wr_done = wr_s & ~wr_prev_q & ~ce_prev_q; // one clock per write

  always @(posedge core_clk) begin
    if (reset) begin
      wr_prev_q <= 1'b1;
      ce_prev_q <= 1'b1;
    end else begin
      wr_prev_q <= wr_s;
      ce_prev_q <= ce_s;
    end
  end

  wire wr_lo = wr_done & (addr_s == `HSR_DA_DATA_LO);
  wire wr_go = wr_done & (addr_s == `HSR_DA_WR_ADDR);
  wire wr_ira = wr_done & (addr_s == `HSR_DA_RD_ADDR);

  // ****************************************************************
  // write holding data and internal write decode
  // ****************************************************************
  reg [15:0] wdata_q;

  always @(posedge core_clk) begin
    if (reset) begin
      wdata_q <= 16'h0000;
    end else if (wr_lo) begin
      wdata_q <= data_s;
    end
  end

  wire glob_wr = wr_go & (data_s[15:12] == `HSR_CH_GLOBAL);
  wire eni_hit = glob_wr & (data_s == `HSR_GWA_TEST_ENI);
  wire sync_hit = glob_wr & (data_s == `HSR_GWA_SYNC_OUT);
  wire slot_hit = wr_go & (data_s[15:5] == `HSR_GWA_SLOT_BASE);
  // agc sampling write, nibble F samples every channel
  wire agc_hit = wr_go & (data_s[11:0] == `HSR_OFS_AGC);

  // ****************************************************************
  // strobe outputs, registered so each spans one clock
  // ****************************************************************
  reg eni_strobe_q;
  reg sync_out_q;
  reg sync_in_prev_q;
  reg sync_event_q;

  always @(posedge core_clk) begin
    if (reset) begin
      eni_strobe_q <= 1'b0;
      sync_out_q <= 1'b0;
      sync_in_prev_q <= 1'b0;
      sync_event_q <= 1'b0;
    end else begin
      eni_strobe_q <= eni_hit;
      sync_out_q <= sync_hit; // data value ignored
      sync_in_prev_q <= sync_in_s;
      sync_event_q <= sync_in_s & ~sync_in_prev_q; // aligns channels
    end
  end

  assign sync_out_pin = sync_out_q;
  assign sync_event = sync_event_q;

  // ****************************************************************
  // per channel: enable source choice and agc gain capture
  // ****************************************************************
  reg [15:0] agc_hold_q [0:3];
  genvar g;

  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ch
      // bit 12 picks the write strobe, otherwise bit 11 is the level
      assign input_enable_strobe[g] = ch_eni_src[g] ? eni_strobe_q : ch_eni_level[g];

      always @(posedge core_clk) begin
        if (reset) begin
          agc_hold_q[g] <= 16'h0000;
        end else if (agc_hit &&
                     (data_s[15:12] == `HSR_CH_GLOBAL || data_s[15:12] == g)) begin
          agc_hold_q[g] <= agc_gain[16*g +: 16]; // same edge for all
        end
      end
    end
  endgenerate

  // ****************************************************************
  // fifo read-order slots
  // ****************************************************************
  reg [4:0] slot_q [0:31];
  integer k;

  always @(posedge core_clk) begin
    if (reset) begin
      for (k = 0; k < `HSR_SLOT_N; k = k + 1) begin
        slot_q[k] <= 5'h00;
      end
    end else if (slot_hit) begin
      slot_q[data_s[4:0]] <= wdata_q[4:0]; // low five bits kept
    end
  end

  // pick one 16-bit word from the channel data by type code
  function [15:0] type_word;
    input [2:0] dt;
    input [23:0] i_w;
    input [23:0] q_w;
    input [23:0] m_w;
    input [15:0] ph_w;
    input [15:0] gn_w;
    begin
      case (dt)
        `HSR_DT_I_HI: type_word = i_w[23:8];
        `HSR_DT_I_LO: type_word = {i_w[7:0], 8'h00};
        `HSR_DT_Q_HI: type_word = q_w[23:8];
        `HSR_DT_Q_LO: type_word = {q_w[7:0], 8'h00};
        `HSR_DT_MAG_HI: type_word = m_w[23:8];
        `HSR_DT_MAG_LO: type_word = {m_w[7:0], 8'h00};
        `HSR_DT_PHASE: type_word = ph_w;
        default: type_word = gn_w;
      endcase
    end
  endfunction

  wire [4:0] cur_slot = slot_q[fifo_slot_idx];
  wire [1:0] cur_ch = cur_slot[4:3]; // channel high, type low
  reg [15:0] fifo_word_q;
  reg [1:0] fifo_chan_q;

  // ****************************************************************
  // fifo word: one clock from slot index to data
  // ****************************************************************
  always @(posedge core_clk) begin
    if (reset) begin
      fifo_word_q <= 16'h0000;
      fifo_chan_q <= 2'h0;
    end else begin
      fifo_chan_q <= cur_ch;
      fifo_word_q <= type_word(cur_slot[2:0], i_data[24*cur_ch +: 24],
                               q_data[24*cur_ch +: 24], mag_data[24*cur_ch +: 24],
                               phase_data[16*cur_ch +: 16], agc_gain[16*cur_ch +: 16]);
    end
  end

  assign fifo_chan = fifo_chan_q;
  assign fifo_word = fifo_word_q;

  // ****************************************************************
  // indirect read address and memory fetch
  // ****************************************************************
  reg [15:0] ira_q;
  reg fetch_q;
  reg fetch_dly_q;
  reg [31:0] fetched_q;
  wire [11:0] ofs_in = data_s[11:0];
  wire ira_mem = (data_s[15:12] != `HSR_CH_GLOBAL) &&
                 (ofs_in >= `HSR_OFS_MEM_LO) && (ofs_in <= `HSR_OFS_MEM_HI);

  always @(posedge core_clk) begin
    if (reset) begin
      ira_q <= 16'h0000;
      fetch_q <= 1'b0;
      fetch_dly_q <= 1'b0;
      fetched_q <= 32'h00000000;
    end else begin
      if (wr_ira) begin
        ira_q <= data_s; // selects the source
      end
      fetch_q <= wr_ira & ira_mem; // fresh strobe on every write of a memory location
      fetch_dly_q <= fetch_q;
      if (fetch_dly_q) begin
        fetched_q <= mem_rd_data; // memory answers one clock after the strobe
      end
    end
  end

  assign mem_fetch = fetch_q;
  assign mem_addr = ira_q;

  // ****************************************************************
  // readback mux: live for unstrobed sources
  // ****************************************************************
  // nibble F on a per-channel source reads channel 0; other nibbles wrap
  wire [1:0] rch = (ira_q[15:12] == `HSR_CH_GLOBAL) ? 2'h0 : ira_q[13:12];
  wire [11:0] rofs = ira_q[11:0];
  reg [31:0] rdata;

  always @* begin
    rdata = 32'h00000000;
    if (ira_q == `HSR_GRA_ILD) begin
      rdata = ild_result;
    end else if (ira_q[15:5] == `HSR_GWA_SLOT_BASE) begin
      rdata = {27'h0000000, slot_q[ira_q[4:0]]};
    end else if (rofs == `HSR_OFS_CARRIER) begin
      rdata = carrier_freq[32*rch +: 32];
    end else if (rofs == `HSR_OFS_TIMING) begin
      rdata = timing_freq[32*rch +: 32];
    end else if (rofs == `HSR_OFS_WAIT) begin
      rdata = wait_counts[32*rch +: 32];
    end else if (rofs == `HSR_OFS_AGC) begin
      rdata = {16'h0000, agc_hold_q[rch]}; // stale until sampled
    end else if (rofs >= `HSR_OFS_MEM_LO && rofs <= `HSR_OFS_MEM_HI) begin
      rdata = fetched_q;
    end
  end

  // ****************************************************************
  // host data bus drive
  // ****************************************************************
  reg [15:0] p_out_q;
  reg p_oe_q;

  always @(posedge core_clk) begin
    if (reset) begin
      p_out_q <= 16'h0000;
      p_oe_q <= 1'b0;
    end else begin
      p_oe_q <= ~ce_s & ~rd_s;
      // direct addresses other than 0 and 1 read as zero
      p_out_q <= (addr_s == `HSR_DA_DATA_HI) ? rdata[31:16] :
                 (addr_s == `HSR_DA_DATA_LO) ? rdata[15:0] : 16'h0000;
    end
  end

  assign p_out = p_out_q;
  assign p_oe = p_oe_q;

endmodule
`default_nettype wire

// [bench/hsr_host_strobe_assertions.sv]
// Purpose: port checker for the host strobe block
// Assumes: bound into hsr_host_strobe, one clock domain
// Notes:   host pins pass two flops, so read timing gets slack
`timescale 1ns/1ns
`default_nettype none
// ********************
// strobe and read checks
// ********************
module hsr_host_strobe_assertions (
  input wire core_clk,
  input wire reset,
  input wire ce_n,
  input wire rd_n,
  input wire p_oe,
  input wire [3:0] ch_eni_level,
  input wire [3:0] ch_eni_src,
  input wire [3:0] input_enable_strobe,
  input wire sync_out_pin,
  input wire sync_event,
  input wire mem_fetch,
  input wire [15:0] mem_addr
);
  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (reset);
  // strobe bits of channels that pick the write strobe
  wire [3:0] sel_stb = input_enable_strobe & ch_eni_src;

  property p_sync_one; sync_out_pin |=> !sync_out_pin; endproperty
  a_sync_one: assert property (p_sync_one) else $error("sync out wider than a clock");
  property p_fetch_one; mem_fetch |=> !mem_fetch; endproperty
  a_fetch_one: assert property (p_fetch_one) else $error("fetch wider than a clock");
  property p_fetch_rng;
    mem_fetch |-> (mem_addr[11:0] >= 12'h100) && (mem_addr[11:0] <= 12'h5FF);
  endproperty
  a_fetch_rng: assert property (p_fetch_rng) else $error("fetch outside memories");
  property p_level; ((input_enable_strobe ^ ch_eni_level) & ~ch_eni_src) == 4'h0; endproperty
  a_level: assert property (p_level) else $error("level enable not passed");
  property p_stb_one; sel_stb != 4'h0 |=> sel_stb == 4'h0; endproperty
  a_stb_one: assert property (p_stb_one) else $error("enable strobe too wide");
  property p_stb_all; sel_stb == 4'h0 || sel_stb == ch_eni_src; endproperty
  a_stb_all: assert property (p_stb_all) else $error("enable strobe not on all");
  property p_oe_on; (!ce_n && !rd_n) [*5] |-> p_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("read not driven");
  property p_oe_off; rd_n [*5] |-> !p_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven without read");
  property p_ev_one; sync_event |=> !sync_event; endproperty
  a_ev_one: assert property (p_ev_one) else $error("sync event too wide");
  property p_rst;
    disable iff (1'b0) reset |=> !(p_oe || sync_out_pin || mem_fetch || sync_event);
  endproperty
  a_rst: assert property (p_rst) else $error("output active in reset");
endmodule
`default_nettype wire

// [bench/hsr_host_model.sv]
// Purpose: microprocessor model on the parallel host bus
// Assumes: pins move 1 ns after a core_clk edge
// Notes:   a released data bus shows the inverse of its last word
`timescale 1ns/1ns
`default_nettype none
// ********************
// host bus driver
// ********************
module hsr_host_model (
  input wire core_clk,
  input wire [15:0] p_out,
  input wire p_oe,
  output logic ce_n,
  output logic wr_n,
  output logic rd_n,
  output logic [2:0] addr,
  output logic [15:0] p_in
);
  int slow = 0; // extra idle clocks, makes a slow host
  // idle bus, write line high through reset
  initial begin
    ce_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    addr = 3'h7;
    p_in = 16'h0000;
  end
  // pins held well past the synced rise, since the device sees it late
  task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic ce);
    @(posedge core_clk);
    #1;
    ce_n = ~ce;
    addr = a;
    p_in = d;
    wr_n = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    wr_n = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    ce_n = 1'b1;
    p_in = ~d; // released lines do not keep the word
    repeat (3 + slow) @(posedge core_clk);
    #1;
  endtask
  // internal write: data word first, then the location
  task automatic iwr(input logic [15:0] loc, input logic [15:0] d);
    wr(3'h0, d, 1'b1);
    wr(3'h2, loc, 1'b1);
  endtask
  // read location written before reading a new source, nibble kept to 0-3 or F
  task automatic sel(input logic [15:0] loc);
    wr(3'h3, loc, 1'b1);
  endtask
  // level read, sampled after the pins settled through the flops
  task automatic rd(input logic [2:0] a, output logic [16:0] v);
    @(posedge core_clk);
    #1;
    ce_n = 1'b0;
    rd_n = 1'b0;
    addr = a;
    repeat (5) @(posedge core_clk);
    #1;
    v = {p_oe, p_out};
    rd_n = 1'b1;
    ce_n = 1'b1;
    repeat (2 + slow) @(posedge core_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// [bench/hsr_host_strobe_tb.sv]
// Purpose: self-checking bench for the host strobe block
// Assumes: host model drives the pins, bench drives channel data
// Notes:   expected words follow from the fixed channel data
`timescale 1ns/1ns
`default_nettype none
// ********************
// bench top
// ********************
module hsr_host_strobe_tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic ce_n, wr_n, rd_n, p_oe, sync_out_pin, sync_event, mem_fetch;
  logic [2:0] addr;
  logic [15:0] p_in, p_out, fifo_word, mem_addr;
  logic sync_in_pin = 1'b0;
  logic [3:0] input_enable_strobe;
  logic [3:0] ch_eni_level = 4'h3;
  logic [3:0] ch_eni_src = 4'h5;
  logic [4:0] fifo_slot_idx = 5'h00;
  logic [1:0] fifo_chan;
  logic [95:0] i_data = {24'hAAAAAA, 24'h123456, 24'h555555, 24'h0F0F0F};
  logic [95:0] q_data = {24'h111111, 24'h789ABC, 24'h222222, 24'h333333};
  logic [95:0] mag_data = {24'h444444, 24'h666666, 24'hDEF012, 24'h777777};
  logic [63:0] phase_data = {16'h3456, 16'h8888, 16'h9999, 16'hAAAA};
  logic [63:0] agc_gain = {16'hBBBB, 16'hCCCC, 16'hDDDD, 16'h7788};
  logic [127:0] carrier_freq = {64'h0, 32'hC1000001, 32'hC0000000};
  logic [127:0] timing_freq = {32'h0, 32'hD2000002, 64'h0};
  logic [127:0] wait_counts = {32'hE3000003, 96'h0};
  logic [31:0] ild_result = 32'h5A5A1234;
  logic [31:0] mem_rd_data = 32'h0;
  logic [1:0] mem_hold = 2'h0;
  int error_cnt = 0, n_checks = 0, cnt_stb = 0, cnt_sync = 0, cnt_ev = 0, cnt_fetch = 0;
  // op bit (0 slot, 1 readback), slot code or location, expected word
  logic [48:0] rows [13] = '{
    {1'b0, 16'h0010, 32'h1234}, {1'b0, 16'h0011, 32'h5600}, {1'b0, 16'h0012, 32'h789A},
    {1'b0, 16'h0013, 32'hBC00}, {1'b0, 16'h000C, 32'hDEF0}, {1'b0, 16'h000D, 32'h1200},
    {1'b0, 16'h001E, 32'h3456}, {1'b0, 16'h0007, 32'h7788}, {1'b1, 16'h1006, 32'hC1000001},
    {1'b1, 16'h2009, 32'hD2000002}, {1'b1, 16'h300C, 32'hE3000003},
    {1'b1, 16'hF806, 32'h5A5A1234}, {1'b1, 16'hF006, 32'hC0000000}};

  hsr_host_strobe u_hsr_host_strobe (.core_clk, .reset, .ce_n, .wr_n, .rd_n, .addr, .p_in,
    .p_out, .p_oe, .ch_eni_level, .ch_eni_src, .input_enable_strobe, .sync_out_pin,
    .sync_in_pin, .sync_event, .fifo_slot_idx, .i_data, .q_data, .mag_data, .phase_data,
    .agc_gain, .fifo_chan, .fifo_word, .carrier_freq, .timing_freq, .wait_counts,
    .ild_result, .mem_fetch, .mem_addr, .mem_rd_data);
  hsr_host_model u_hsr_host_model (.core_clk, .p_out, .p_oe, .ce_n, .wr_n, .rd_n, .addr,
    .p_in);

  always #10 core_clk = ~core_clk;
  // sync fed back through one pipeline stage, pulse and strobe counters
  always @(posedge core_clk) begin
    sync_in_pin <= sync_out_pin;
    cnt_stb <= cnt_stb + ((input_enable_strobe & ch_eni_src) != 4'h0);
    cnt_sync <= cnt_sync + sync_out_pin;
    cnt_ev <= cnt_ev + sync_event;
    cnt_fetch <= cnt_fetch + mem_fetch;
  end
  // memory answers a clock after the fetch, word goes stale after three
  always @(posedge core_clk) begin
    if (mem_fetch) begin
      mem_rd_data <= {mem_addr, ~mem_addr};
      mem_hold <= 2'h2;
    end else if (mem_hold != 2'h0) begin
      mem_hold <= mem_hold - 2'h1;
    end else begin
      mem_rd_data <= ~mem_rd_data;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // read with the bus driven and the expected low or high half
  task automatic rdc(input logic [2:0] a, input logic [15:0] e);
    logic [16:0] v;
    u_hsr_host_model.rd(a, v);
    chk(v, {1'b1, e});
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // watchdog, far beyond the expected 750 or so clocks
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    #1 reset = 1'b0;
    chk(p_oe, 0);
    chk(sync_out_pin, 0);
    chk(input_enable_strobe, 4'h2);
    for (int i = 0; i < 13; i++) begin
      if (!rows[i][48]) begin
        u_hsr_host_model.iwr(16'hF820 + i[15:0], rows[i][47:32]);
        #1 fifo_slot_idx = i[4:0];
        repeat (2) @(posedge core_clk);
        #1 chk(fifo_word, rows[i][15:0]);
        chk(fifo_chan, rows[i][36:35]);
        u_hsr_host_model.sel(16'hF820 + i[15:0]);
        rdc(3'h0, rows[i][47:32]);
      end else begin
        u_hsr_host_model.sel(rows[i][47:32]);
        rdc(3'h0, rows[i][15:0]);
        rdc(3'h1, rows[i][31:16]);
      end
    end
    chk(cnt_fetch, 0);
    carrier_freq[15:0] = 16'h4321;
    rdc(3'h0, 16'h4321);
    u_hsr_host_model.iwr(16'hF808, 16'hFFFF);
    chk(cnt_stb, 1);
    u_hsr_host_model.wr(3'h2, 16'hF809, 1'b0);
    chk(cnt_sync, 0);
    u_hsr_host_model.iwr(16'hF809, 16'h0000);
    repeat (4) @(posedge core_clk);
    chk(cnt_sync, 1);
    chk(cnt_ev, 1);
    u_hsr_host_model.iwr(16'hF00F, 16'h0000);
    agc_gain[15:0] = 16'h0101;
    u_hsr_host_model.sel(16'h000F);
    rdc(3'h0, 16'h7788);
    u_hsr_host_model.sel(16'h300F);
    rdc(3'h0, 16'hBBBB);
    u_hsr_host_model.iwr(16'hF00F, 16'h0000);
    u_hsr_host_model.sel(16'h000F);
    rdc(3'h0, 16'h0101);
    u_hsr_host_model.slow = 4;
    u_hsr_host_model.sel(16'h2480);
    chk(mem_addr, 16'h2480);
    rdc(3'h0, 16'hDB7F);
    rdc(3'h1, 16'h2480);
    u_hsr_host_model.sel(16'h2480);
    chk(cnt_fetch, 2);
    rdc(3'h4, 16'h0000);
    // level enable follows bit 11 on channels without the strobe source
    ch_eni_level = 4'hC;
    #1 chk(input_enable_strobe, 4'h8);
    // mid-run reset clears the read address and the read-order slots
    reset = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 reset = 1'b0;
    chk(p_oe, 0);
    chk(mem_addr, 16'h0000);
    u_hsr_host_model.sel(16'hF827);
    rdc(3'h0, 16'h0000);
    summarize();
  end
endmodule

bind hsr_host_strobe hsr_host_strobe_assertions u_hsr_host_strobe_assertions (.core_clk,
  .reset, .ce_n, .rd_n, .p_oe, .ch_eni_level, .ch_eni_src, .input_enable_strobe,
  .sync_out_pin, .sync_event, .mem_fetch, .mem_addr);
`default_nettype wire
